// file: dv/sksx_mem_model.sv
// sksx_mem_model: data memory partner of the execution datapath
`timescale 1ns/1ns
module sksx_mem_model (
  // clock
  input  wire logic                     clock,
  // address from the fetch side, write from the datapath
  input  wire logic [3:0]               addr,
  input  wire sksx_pkg::sksx_memwr_type memWrite,
  // operand byte
  output logic [7:0]                    memData
);
  logic [7:0] mem [16];
  logic [3:0] lastAddr;

  // read follows the current address
  assign memData = mem[addr];

  // a write lands where the instruction that caused it pointed
  always @(posedge clock) begin
    lastAddr <= addr;
    if (memWrite.enable === 1'b1) begin
      mem[lastAddr] <= memWrite.data;
    end
  end

  // empty memory at start
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
endmodule : sksx_mem_model

// file: dv/tb.sv
// tb: self-checking bench of the skip, subtract and swap datapath
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    sksx_pkg::sksx_op_type op;
    logic [3:0]            addr;
    logic [2:0]            bitSel;
    logic [7:0]            imm;
    logic [7:0]            acc;
    logic [3:0]            flg;
    logic                  wen;
    logic [7:0]            wdat;
    logic                  skip;
  } sksx_row_type;

  logic                     clock = 1'b0;
  logic                     rst = 1'b1;
  logic                     instrValid = 1'b0;
  sksx_pkg::sksx_instr_type instr = '0;
  logic [3:0]               addr = 4'h0;
  logic [7:0]               memData;
  sksx_pkg::sksx_memwr_type memWrite;
  logic [7:0]               accum;
  sksx_pkg::sksx_flags_type flags;
  logic                     skipNext;
  logic                     dummySlot;
  logic                     busy;
  int                       bad_count = 0;
  int                       checks = 0;

  // ordinary cases: inputs, then accum, flags, write and skip
  sksx_row_type rows [7] = '{
    '{sksx_pkg::SKSX_OP_DEDUCT_IMM, 4'h0, 3'h0, 8'h00,
      8'h00, 4'h7, 1'b0, 8'h00, 1'b0},
    '{sksx_pkg::SKSX_OP_INCR_SKIP_ZERO_ACCUM, 4'h1, 3'h0, 8'h00,
      8'h13, 4'h7, 1'b0, 8'h00, 1'b0},
    '{sksx_pkg::SKSX_OP_DEDUCT_MEM_INTO_ACCUM, 4'h1, 3'h0, 8'h00,
      8'h01, 4'h3, 1'b0, 8'h00, 1'b0},
    '{sksx_pkg::SKSX_OP_DEDUCT_INTO_MEM, 4'h2, 3'h0, 8'h00,
      8'h01, 4'hA, 1'b1, 8'h81, 1'b0},
    '{sksx_pkg::SKSX_OP_NIBBLE_EXCHANGE_MEM, 4'h1, 3'h0, 8'h00,
      8'h01, 4'hA, 1'b1, 8'h21, 1'b0},
    '{sksx_pkg::SKSX_OP_NIBBLE_EXCHANGE_TO_ACCUM, 4'h2, 3'h0, 8'h00,
      8'h18, 4'hA, 1'b0, 8'h00, 1'b0},
    '{sksx_pkg::SKSX_OP_DEDUCT_IMM, 4'h0, 3'h0, 8'h19,
      8'hFF, 4'h0, 1'b0, 8'h00, 1'b0}};

  sksx_exec sksx_exec_inst (.clock(clock), .rst(rst),
    .instrValid(instrValid), .instr(instr), .memData(memData),
    .memWrite(memWrite), .accum(accum), .flags(flags),
    .skipNext(skipNext), .dummySlot(dummySlot), .busy(busy));
  sksx_mem_model sksx_mem_model_inst (.clock(clock), .addr(addr),
    .memWrite(memWrite), .memData(memData));

  // 100 MHz clock
  always #5 clock = ~clock;

  // byte compare
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: byte %h want %h", $time, got, exp);
    end
  endtask : chkByte

  // single bit compare
  task automatic chkBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: bit %b want %b", $time, got, exp);
    end
  endtask : chkBit

  // offer one instruction, let the taking edge pass
  task automatic step(input logic v, input sksx_pkg::sksx_op_type op,
                      input logic [3:0] a, input logic [2:0] b,
                      input logic [7:0] x);
    instrValid = v;
    instr.op = op;
    instr.bitSel = b;
    instr.immediate = x;
    addr = a;
    @(posedge clock);
    #1;
  endtask : step

  // all results of one instruction
  task automatic checkOut(input logic [7:0] acc, input logic [3:0] flg,
                          input logic wen, input logic [7:0] wdat,
                          input logic skip);
    chkByte(accum, acc);
    chkByte({4'h0, flags}, {4'h0, flg});
    chkBit(memWrite.enable, wen);
    if (wen) chkByte(memWrite.data, wdat);
    chkBit(skipNext, skip);
    chkBit(dummySlot, skip);
    chkBit(busy, skip);
  endtask : checkOut

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    #1;
    checkOut(8'h00, 4'h0, 1'b0, 8'h00, 1'b0);
    rst = 1'b0;
    sksx_mem_model_inst.mem[0] = 8'hFF;
    sksx_mem_model_inst.mem[1] = 8'h12;
    sksx_mem_model_inst.mem[2] = 8'h80;
    foreach (rows[i]) begin
      step(1'b1, rows[i].op, rows[i].addr, rows[i].bitSel, rows[i].imm);
      checkOut(rows[i].acc, rows[i].flg, rows[i].wen,
               rows[i].wdat, rows[i].skip);
    end
    // clear selected bit, no skip; set bit skips, offer in dummy ignored
    step(1'b1, sksx_pkg::SKSX_OP_BIT_SET_SKIP, 4'h1, 3'h1, 8'h00);
    checkOut(8'hFF, 4'h0, 1'b0, 8'h00, 1'b0);
    step(1'b1, sksx_pkg::SKSX_OP_BIT_SET_SKIP, 4'h1, 3'h0, 8'h00);
    checkOut(8'hFF, 4'h0, 1'b0, 8'h00, 1'b1);
    step(1'b1, sksx_pkg::SKSX_OP_DEDUCT_IMM, 4'h0, 3'h0, 8'h01);
    checkOut(8'hFF, 4'h0, 1'b0, 8'h00, 1'b0);
    // increment wraps to zero and skips, memory kept
    step(1'b1, sksx_pkg::SKSX_OP_INCR_SKIP_ZERO_ACCUM, 4'h0, 3'h0, 8'h00);
    checkOut(8'h00, 4'h0, 1'b0, 8'h00, 1'b1);
    step(1'b0, sksx_pkg::SKSX_OP_NONE, 4'h0, 3'h0, 8'h00);
    chkByte(memData, 8'hFF);
    // reset in mid-run, then subtract at the first edge after release
    step(1'b1, sksx_pkg::SKSX_OP_DEDUCT_IMM, 4'h0, 3'h0, 8'h01);
    rst = 1'b1;
    #1;
    checkOut(8'h00, 4'h0, 1'b0, 8'h00, 1'b0);
    @(posedge clock);
    #1;
    rst = 1'b0;
    step(1'b1, sksx_pkg::SKSX_OP_DEDUCT_IMM, 4'h0, 3'h0, 8'h80);
    checkOut(8'h80, 4'hA, 1'b0, 8'h00, 1'b0);
    summarize();
  end
endmodule : tb

// file: rtl/sksx_exec.sv
// sksx_exec: execution datapath for skip, subtract and nibble-swap group
//
// Summary of operation
// - increment-skip writes byte plus one to accumulator
// - skip next instruction when incremented byte is zero
// - taken skip costs two cycles via dummy
// - bit-set skip skips when selected bit is one
// - subtract memory from accumulator, flags updated
// - no-borrow cleared on negative, else set
// - subtract into memory writes difference back
// - immediate subtract from accumulator, flags updated
// - nibble swap in memory, flags untouched
// - nibble swap into accumulator, memory untouched
`timescale 1ns/1ns
module sksx_exec (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // instruction from the fetch unit
  input  wire logic                      instrValid,
  input  wire sksx_pkg::sksx_instr_type  instr,
  // operand read from data memory
  input  wire logic [7:0]                memData,
  // data memory write request
  output sksx_pkg::sksx_memwr_type       memWrite,
  // architectural state
  output logic [7:0]                     accum,
  output sksx_pkg::sksx_flags_type       flags,
  // fetch control
  output logic                           skipNext,
  output logic                           dummySlot,
  output logic                           busy
);

  // nibble exchange used for both swap forms
  function automatic logic [7:0] nibble_swap(input logic [7:0] v);
    nibble_swap = {v[3:0], v[7:4]};
  endfunction : nibble_swap

  // operation decode, shared by the datapath and its checks
  function automatic logic op_is(input sksx_pkg::sksx_op_type op,
                                 input sksx_pkg::sksx_op_type want);
    op_is = (op == want);
  endfunction : op_is

  sksx_pkg::sksx_op_type     activeOp;
  sksx_pkg::sksx_flags_type  subFlags;
  sksx_pkg::sksx_flags_type  next_flags;
  sksx_pkg::sksx_memwr_type  next_memWrite;
  logic [7:0]                subMinus;
  logic [7:0]                subDiff;
  logic [7:0]                incrValue;
  logic [7:0]                next_accum;
  logic                      selBit;
  logic                      takeSkip;
  logic                      isSubtract;
  logic                      dummyPending;
  logic                      issue;
  logic                      isIncr;
  logic                      isBitSkip;
  logic                      isSubAcc;
  logic                      isSubMem;
  logic                      isSubImm;
  logic                      isSwapMem;
  logic                      isSwapAcc;

  typedef enum logic {SKSX_RUN, SKSX_DUMMY} sksx_state_type;
  sksx_state_type state;
  sksx_state_type next_state;

  // instructions are taken only outside the dummy slot
  assign issue    = instrValid & (state == SKSX_RUN);
  assign activeOp = issue ? instr.op : sksx_pkg::SKSX_OP_NONE;

  // one strobe per taken operation
  // all low in the dummy slot, so an offer there does nothing
  assign isIncr    = op_is(activeOp,
                           sksx_pkg::SKSX_OP_INCR_SKIP_ZERO_ACCUM);
  assign isBitSkip = op_is(activeOp,
                           sksx_pkg::SKSX_OP_BIT_SET_SKIP);
  assign isSubAcc  = op_is(activeOp,
                           sksx_pkg::SKSX_OP_DEDUCT_MEM_INTO_ACCUM);
  assign isSubMem  = op_is(activeOp,
                           sksx_pkg::SKSX_OP_DEDUCT_INTO_MEM);
  assign isSubImm  = op_is(activeOp,
                           sksx_pkg::SKSX_OP_DEDUCT_IMM);
  assign isSwapMem = op_is(activeOp,
                           sksx_pkg::SKSX_OP_NIBBLE_EXCHANGE_MEM);
  assign isSwapAcc = op_is(activeOp,
                           sksx_pkg::SKSX_OP_NIBBLE_EXCHANGE_TO_ACCUM);

  // operand selection and shared subtractor
  // the immediate form borrows the memory subtract path
  assign subMinus   = isSubImm ? instr.immediate : memData;
  assign incrValue  = memData + sksx_pkg::ONE_BYTE;
  assign selBit     = memData[instr.bitSel];
  assign isSubtract = isSubAcc | isSubMem | isSubImm;

  sksx_subtractor u_sub (
    .minuend    (accum),
    .subtrahend (subMinus),
    .difference (subDiff),
    .flags      (subFlags)
  );

  // skip decision
  // only a taken skip opens the dummy slot
  assign takeSkip =
      (isIncr & (incrValue == sksx_pkg::ZERO_BYTE))
    | (isBitSkip & selBit);

  // next accumulator, flags and memory write
  always_comb begin
    next_accum           = accum;
    next_flags           = flags;
    next_memWrite.enable = 1'b0;
    next_memWrite.data   = sksx_pkg::ZERO_BYTE;
    unique case (activeOp)
      sksx_pkg::SKSX_OP_INCR_SKIP_ZERO_ACCUM: begin
        next_accum = incrValue;
      end
      sksx_pkg::SKSX_OP_DEDUCT_MEM_INTO_ACCUM,
      sksx_pkg::SKSX_OP_DEDUCT_IMM: begin
        next_accum = subDiff;
        next_flags = subFlags;
      end
      sksx_pkg::SKSX_OP_DEDUCT_INTO_MEM: begin
        next_memWrite.enable = 1'b1;
        next_memWrite.data   = subDiff;
        next_flags           = subFlags;
      end
      sksx_pkg::SKSX_OP_NIBBLE_EXCHANGE_MEM: begin
        next_memWrite.enable = 1'b1;
        next_memWrite.data   = nibble_swap(memData);
      end
      sksx_pkg::SKSX_OP_NIBBLE_EXCHANGE_TO_ACCUM: begin
        next_accum = nibble_swap(memData);
      end
      default: begin
      end
    endcase
  end

  // dummy slot sequencing for taken skips
  assign next_state   = (state == SKSX_RUN && takeSkip) ? SKSX_DUMMY
                                                        : SKSX_RUN;
  assign dummyPending = (next_state == SKSX_DUMMY);

  // architectural registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accum    <= sksx_pkg::ACC_RESET;
      flags    <= sksx_pkg::FLAGS_RESET;
      memWrite <= '0;
    end else begin
      accum    <= next_accum;
      flags    <= next_flags;
      memWrite <= next_memWrite;
    end
  end

  // fetch control registers
  // busy mirrors the dummy slot; offers then are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state     <= SKSX_RUN;
      skipNext  <= 1'b0;
      dummySlot <= 1'b0;
      busy      <= 1'b0;
    end else begin
      state     <= next_state;
      skipNext  <= takeSkip;
      dummySlot <= dummyPending;
      busy      <= dummyPending;
    end
  end

  // checks
  // sign-extended difference, read by the overflow check only
  // nine bits hold every exact result, so bits 8 and 7 differ on overflow
  logic [8:0] signedWide;
  assign signedWide = {accum[7], accum} - {subMinus[7], subMinus};

  // increment and skip forms
  chk_incr_accum: assert property (
    @(posedge clock) disable iff (rst)
    isIncr |=> accum == $past(memData) + 8'h01 && !memWrite.enable)
    else $error("increment result wrong");

  chk_incr_skip: assert property (
    @(posedge clock) disable iff (rst)
    isIncr |=> skipNext == (accum == 8'h00))
    else $error("increment skip mismatch");

  chk_bit_skip: assert property (
    @(posedge clock) disable iff (rst)
    isBitSkip |=> skipNext == $past(memData[instr.bitSel]))
    else $error("bit skip mismatch");

  chk_skip_source: assert property (
    @(posedge clock) disable iff (rst)
    skipNext |-> $past(isIncr) || $past(isBitSkip))
    else $error("skip without a skip instruction");

  // dummy slot after a taken skip
  chk_skip_two_cycles: assert property (
    @(posedge clock) disable iff (rst)
    skipNext |-> dummySlot ##1 !dummySlot)
    else $error("skip not two cycles");

  chk_skip_pulse: assert property (
    @(posedge clock) disable iff (rst)
    skipNext |=> !skipNext)
    else $error("skip held past one cycle");

  chk_busy_dummy: assert property (
    @(posedge clock) disable iff (rst)
    busy == dummySlot)
    else $error("busy differs from dummy slot");

  chk_dummy_ignored: assert property (
    @(posedge clock) disable iff (rst)
    dummySlot |=> !skipNext && !memWrite.enable
                  && $stable(accum) && $stable(flags))
    else $error("instruction taken in dummy slot");

  // subtract forms and their flags
  chk_sub_accum: assert property (
    @(posedge clock) disable iff (rst)
    isSubAcc |=> accum == $past(accum) - $past(memData))
    else $error("subtract to accumulator wrong");

  chk_no_borrow: assert property (
    @(posedge clock) disable iff (rst)
    isSubtract |=> flags.noBorrowBit == ($past(accum) >= $past(subMinus)))
    else $error("no-borrow flag wrong");

  chk_sub_mem: assert property (
    @(posedge clock) disable iff (rst)
    isSubMem |=> memWrite.enable
                 && memWrite.data == $past(accum) - $past(memData)
                 && accum == $past(accum))
    else $error("subtract to memory wrong");

  chk_sub_imm: assert property (
    @(posedge clock) disable iff (rst)
    isSubImm |=> accum == $past(accum) - $past(instr.immediate))
    else $error("immediate subtract wrong");

  chk_zero_flag: assert property (
    @(posedge clock) disable iff (rst)
    isSubtract |=> flags.nullResultBit == ($past(accum) == $past(subMinus)))
    else $error("zero flag wrong");

  chk_half_borrow: assert property (
    @(posedge clock) disable iff (rst)
    isSubtract |=> flags.halfBorrowBit
                   == ($past(accum[3:0]) >= $past(subMinus[3:0])))
    else $error("half-borrow flag wrong");

  chk_signed_range: assert property (
    @(posedge clock) disable iff (rst)
    isSubtract |=> flags.signedRangeBit
                   == $past(signedWide[8] ^ signedWide[7]))
    else $error("overflow flag wrong");

  // nibble exchange forms
  chk_swap_mem: assert property (
    @(posedge clock) disable iff (rst)
    isSwapMem |=> memWrite.enable && $stable(flags)
                  && memWrite.data[7:4] == $past(memData[3:0])
                  && memWrite.data[3:0] == $past(memData[7:4]))
    else $error("memory swap wrong");

  chk_swap_accum: assert property (
    @(posedge clock) disable iff (rst)
    isSwapAcc |=> !memWrite.enable
                  && accum[7:4] == $past(memData[3:0])
                  && accum[3:0] == $past(memData[7:4]))
    else $error("accumulator swap wrong");

  chk_write_source: assert property (
    @(posedge clock) disable iff (rst)
    memWrite.enable |-> $past(isSubMem) || $past(isSwapMem))
    else $error("memory written by a read-only form");

  // flags move only on a subtract
  chk_flags_held: assert property (
    @(posedge clock) disable iff (rst)
    !isSubtract |=> $stable(flags))
    else $error("flags changed without subtract");

  cov_skip_incr: cover property (@(posedge clock) disable iff (rst)
    issue && instr.op == sksx_pkg::SKSX_OP_INCR_SKIP_ZERO_ACCUM && takeSkip);
  cov_skip_bit: cover property (@(posedge clock) disable iff (rst)
    issue && instr.op == sksx_pkg::SKSX_OP_BIT_SET_SKIP && takeSkip);
  cov_borrow: cover property (@(posedge clock) disable iff (rst)
    issue && isSubtract && !subFlags.noBorrowBit);
  cov_overflow: cover property (@(posedge clock) disable iff (rst)
    issue && isSubtract && subFlags.signedRangeBit);

  // an offer dropped in the dummy slot
  cov_dummy_offer: cover property (@(posedge clock) disable iff (rst)
    dummySlot && instrValid);

endmodule : sksx_exec

// file: rtl/sksx_pkg.sv
// sksx_pkg: shared types and constants of the skip/subtract/swap datapath
package sksx_pkg;

  localparam int DATA_WIDTH = 8;
  localparam int BIT_SEL_WIDTH = 3;
  localparam int NIBBLE = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // cycles taken by a skip that is taken (dummy slot included)
  localparam int SKIP_CYCLES = 2;
  localparam logic [1:0] DUMMY_COUNT = 2'h1;

  // operations carried out by this group
  typedef enum logic [2:0] {
    SKSX_OP_NONE,
    SKSX_OP_INCR_SKIP_ZERO_ACCUM,
    SKSX_OP_BIT_SET_SKIP,
    SKSX_OP_DEDUCT_MEM_INTO_ACCUM,
    SKSX_OP_DEDUCT_INTO_MEM,
    SKSX_OP_DEDUCT_IMM,
    SKSX_OP_NIBBLE_EXCHANGE_MEM,
    SKSX_OP_NIBBLE_EXCHANGE_TO_ACCUM
  } sksx_op_type;

  // status flags held by the core
  typedef struct packed {
    logic signedRangeBit;
    logic nullResultBit;
    logic halfBorrowBit;
    logic noBorrowBit;
  } sksx_flags_type;

  // status flags after reset
  localparam sksx_flags_type FLAGS_RESET = 4'h0;

  // one instruction issued by the fetch unit
  typedef struct packed {
    sksx_op_type               op;
    logic [BIT_SEL_WIDTH-1:0]  bitSel;
    logic [DATA_WIDTH-1:0]     immediate;
  } sksx_instr_type;

  // write request toward data memory
  typedef struct packed {
    logic                  enable;
    logic [DATA_WIDTH-1:0] data;
  } sksx_memwr_type;

endpackage : sksx_pkg

// file: rtl/sksx_subtractor.sv
// sksx_subtractor: 8-bit subtract with status flag generation
`timescale 1ns/1ns
module sksx_subtractor (
  // operands
  input  wire logic [7:0]              minuend,
  input  wire logic [7:0]              subtrahend,
  // result
  output logic [7:0]                   difference,
  output sksx_pkg::sksx_flags_type     flags
);

  logic [8:0] fullDiff;
  logic [4:0] lowDiff;

  // full and low-nibble differences, borrow is the top bit
  assign fullDiff   = {1'b0, minuend} - {1'b0, subtrahend};
  assign lowDiff    = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign difference = fullDiff[7:0];

  // flag generation
  assign flags.noBorrowBit    = ~fullDiff[8];
  assign flags.nullResultBit  = (fullDiff[7:0] == 8'h00);
  assign flags.halfBorrowBit  = ~lowDiff[4];
  assign flags.signedRangeBit = (minuend[7] ^ subtrahend[7])
                              & (minuend[7] ^ fullDiff[7]);

endmodule : sksx_subtractor
